// >>> hdl/mso_params.svh
`ifndef MSO_PARAMS_SVH
`define MSO_PARAMS_SVH

// instruction pointer and return stack
`define MSO_IP_W        12
`define MSO_RESET_IP    12'hffe
`define MSO_STACK_DEPTH 6
`define MSO_DEPTH_W     3

// data space map
`define MSO_RAM_TOP     8'h3f
`define MSO_WIN_FIRST   8'h40
`define MSO_WIN_LAST    8'h7f
`define MSO_IDX_FIRST   8'h80
`define MSO_IDX_LAST    8'h83
`define MSO_PDAT_OFS    8'hc0
`define MSO_PDIR_OFS    8'hc4
`define MSO_IOR_OFS     8'hc8
`define MSO_WSEL_OFS    8'hc9
`define MSO_POPT_OFS    8'hcc
`define MSO_ACC_OFS     8'hff

// field layout
`define MSO_WSEL_W      6
`define MSO_WOFS_W      6
`define MSO_PORTS       3
`define MSO_PORT_BITS   24
`define MSO_RAM_WORDS   64

// reset values
`define MSO_PORT_RST    24'h000000
`define MSO_PULL_RST    24'hffffff
`define MSO_BYTE_RST    8'h00
`define MSO_WSEL_RST    6'h00

`endif

// >>> hdl/mso_pkg.sv
package mso_pkg;

	// which resource a data-space address lands on
	typedef enum {
		MSO_RG_RAM,
		MSO_RG_WIN,
		MSO_RG_IDX,
		MSO_RG_PDAT,
		MSO_RG_PDIR,
		MSO_RG_POPT,
		MSO_RG_IOR,
		MSO_RG_WSEL,
		MSO_RG_ACC,
		MSO_RG_NONE
	} mso_region_t;

	// second read port of program memory
	typedef enum {
		MSO_RD_IDLE,
		MSO_RD_WIN,
		MSO_RD_EXT
	} mso_rd_state_t;

endpackage : mso_pkg

// >>> hdl/mso_retstack.sv
`timescale 1ns/1ps
`include "mso_params.svh"

module mso_retstack import mso_pkg::*; (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// stack operations
	input  wire logic                      push,
	input  wire logic                      pop,
	input  wire logic [`MSO_IP_W-1:0]      push_data,
	// state
	output logic      [`MSO_IP_W-1:0]      top,
	output logic      [`MSO_DEPTH_W-1:0]   depth,
	output logic                           ovf
);

	logic [`MSO_IP_W-1:0]    ent      [0:`MSO_STACK_DEPTH-1];
	logic [`MSO_IP_W-1:0]    next_ent [0:`MSO_STACK_DEPTH-1];
	logic [`MSO_DEPTH_W-1:0] next_depth;
	logic                    next_ovf;

	// shift stack: a push beyond six levels drops the oldest entry
	for (genvar i = 0; i < `MSO_STACK_DEPTH; i++) begin : g_ent
		always_comb begin
			next_ent[i] = ent[i];
			if (push) begin
				if (i == 0) begin
					next_ent[i] = push_data; // see [RQ3]
				end else begin
					next_ent[i] = ent[i-1];
				end
			end else if (pop) begin
				if (i < `MSO_STACK_DEPTH - 1) begin
					next_ent[i] = ent[i+1];
				end
			end
		end
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				ent[i] <= `MSO_RESET_IP;
			end else begin
				ent[i] <= next_ent[i];
			end
		end
	end

	// level count saturates at the stack depth
	always_comb begin
		next_depth = depth;
		next_ovf   = 1'b0;
		if (push) begin
			if (depth == `MSO_DEPTH_W'(`MSO_STACK_DEPTH)) begin
				next_ovf = 1'b1; // see [RQ3]
			end else begin
				next_depth = depth + 1'b1;
			end
		end else if (pop && depth != '0) begin
			next_depth = depth - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			depth <= '0;
			ovf   <= 1'b0;
		end else begin
			depth <= next_depth;
			ovf   <= next_ovf;
		end
	end

	assign top = ent[0];

	AST_DEPTH_MAX: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ3]
		depth <= `MSO_DEPTH_W'(`MSO_STACK_DEPTH))
		else $error("return stack deeper than six levels");

	AST_OVF_SEVENTH: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ3]
		push && depth == `MSO_DEPTH_W'(`MSO_STACK_DEPTH) |=> ovf && depth == $past(depth))
		else $error("seventh push not flagged");

endmodule : mso_retstack

// >>> hdl/mso_memspace.sv
`timescale 1ns/1ps
`include "mso_params.svh"

// Operation
// [RQ1] program, data and stack spaces are reached by separate ports, not one shared map.
// [RQ2] fetch addresses come from a 12-bit instruction pointer reaching 4K of program memory.
// [RQ3] a six-entry 12-bit return stack saves the pointer on calls and interrupt entry.
// [RQ4] data space has a 64-byte window that reads constants held in program memory.
// [RQ5] data space holds user RAM, accumulator, index, short direct, port, option and select registers.
// [RQ6] with readout protection set, every external read of program memory is refused.
// [RQ7] protection is cleared only by a full erase, which also wipes all program memory.
// [RQ8] the non-maskable interrupt input fires on a falling edge, not a level.
// [RQ9] reset is active low and outranks every interrupt source.
// [RQ10] after reset every port pin is an input with pull-up until software changes it.
// [RQ11] a high programming level seen during reset enters programming mode, else normal run.
// [RQ12] the window sits at data addresses 40h to 7Fh and selects one 64-byte block.
// [RQ13] the window select is write-only, so software must load it before the first window read.
// [RQ14] a window read addresses program memory with the block number above the low six bits.
module mso_memspace import mso_pkg::*; (
	// clock and reset
	input  wire logic                      MCLK,
	input  wire logic                      NRST,
	// pins
	input  wire logic                      NMI_PIN,
	input  wire logic                      VPP_HIGH,
	input  wire logic [`MSO_PORT_BITS-1:0] PORT_PIN_IN,
	output logic      [`MSO_PORT_BITS-1:0] PORT_OUT,
	output logic      [`MSO_PORT_BITS-1:0] PORT_OE,
	output logic      [`MSO_PORT_BITS-1:0] PORT_PULLUP,
	// option cell and programmer
	input  wire logic                      OPT_PROTECT,
	input  wire logic                      PROT_SET,
	input  wire logic                      ERASE_REQ,
	input  wire logic                      EXT_RD_REQ,
	input  wire logic [`MSO_IP_W-1:0]      EXT_RD_ADDR,
	output logic      [7:0]                EXT_RD_DATA,
	output logic                           EXT_RD_VALID,
	output logic                           EXT_RD_REFUSED,
	output logic                           ERASE_ALL,
	output logic                           PROG_MODE,
	output logic                           PROTECTED,
	// instruction pointer control
	input  wire logic                      IP_STEP,
	input  wire logic                      IP_JUMP,
	input  wire logic                      IP_CALL,
	input  wire logic                      IP_INT,
	input  wire logic                      IP_RET,
	input  wire logic [`MSO_IP_W-1:0]      IP_TARGET,
	output logic      [`MSO_IP_W-1:0]      FETCH_ADDR,
	output logic                           STACK_OVF,
	output logic                           NMI_REQ,
	// data space
	input  wire logic                      DATA_RD,
	input  wire logic                      DATA_WR,
	input  wire logic [7:0]                DATA_ADDR,
	input  wire logic [7:0]                DATA_WDATA,
	output logic      [7:0]                DATA_RDATA,
	output logic                           DATA_RVALID,
	output logic      [7:0]                INT_OPTION,
	// second read port of program memory
	output logic      [`MSO_IP_W-1:0]      ROM_RADDR,
	output logic                           ROM_RD,
	input  wire logic [7:0]                ROM_RDATA
);

	// map a data address onto its resource; used by reads and writes
	function automatic mso_region_t region_of(input logic [7:0] a);
		if (a <= `MSO_RAM_TOP) begin
			return MSO_RG_RAM;
		end
		if (a >= `MSO_WIN_FIRST && a <= `MSO_WIN_LAST) begin
			return MSO_RG_WIN; // see [RQ12]
		end
		if (a >= `MSO_IDX_FIRST && a <= `MSO_IDX_LAST) begin
			return MSO_RG_IDX;
		end
		if (a[7:2] == `MSO_PDAT_OFS >> 2 && a[1:0] != 2'h3) begin
			return MSO_RG_PDAT;
		end
		if (a[7:2] == `MSO_PDIR_OFS >> 2 && a[1:0] != 2'h3) begin
			return MSO_RG_PDIR;
		end
		if (a[7:2] == `MSO_POPT_OFS >> 2 && a[1:0] != 2'h3) begin
			return MSO_RG_POPT;
		end
		if (a == `MSO_IOR_OFS) begin
			return MSO_RG_IOR;
		end
		if (a == `MSO_WSEL_OFS) begin
			return MSO_RG_WSEL;
		end
		if (a == `MSO_ACC_OFS) begin
			return MSO_RG_ACC;
		end
		return MSO_RG_NONE;
	endfunction : region_of

	// pin synchronisers; first stages feed only the second stages
	logic                      nmi_s1, nmi_s2, nmi_s3;
	logic                      vpp_s1, vpp_s2;
	logic [`MSO_PORT_BITS-1:0] pin_s1, pin_s2;

	always_ff @(posedge MCLK) begin
		nmi_s1 <= NMI_PIN;
		nmi_s2 <= nmi_s1;
		vpp_s1 <= VPP_HIGH;
		vpp_s2 <= vpp_s1;
		pin_s1 <= PORT_PIN_IN;
		pin_s2 <= pin_s1;
	end

	// mode, protection and interrupt edge state
	logic next_nmi_s3, next_nmi_req, next_prot, next_erase;

	always_comb begin
		next_nmi_s3  = nmi_s2;
		next_nmi_req = nmi_s3 & ~nmi_s2 & ~PROG_MODE; // see [RQ8]
		next_erase   = ERASE_REQ & PROG_MODE; // see [RQ7]
		next_prot    = PROTECTED;
		if (next_erase) begin
			next_prot = 1'b0; // see [RQ7]
		end
		if (PROT_SET && PROG_MODE) begin
			next_prot = 1'b1; // a set in the same cycle wins over the erase
		end
	end

	// reset tracks the pin level, so a fall under reset raises no interrupt at release
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			nmi_s3    <= nmi_s2; // see [RQ9]
			NMI_REQ   <= 1'b0; // see [RQ9]
			ERASE_ALL <= 1'b0;
			PROG_MODE <= vpp_s2; // see [RQ11]
			PROTECTED <= OPT_PROTECT;
		end else begin
			nmi_s3    <= next_nmi_s3;
			NMI_REQ   <= next_nmi_req;
			ERASE_ALL <= next_erase;
			PROTECTED <= next_prot;
		end
	end

	// instruction pointer; the core is frozen while programming
	logic                   st_push, st_pop, ovf;
	logic [`MSO_IP_W-1:0]   st_top, next_ip;
	logic [`MSO_DEPTH_W-1:0] st_depth;

	always_comb begin
		st_pop  = IP_RET & ~PROG_MODE;
		st_push = (IP_CALL | IP_INT) & ~IP_RET & ~PROG_MODE; // see [RQ3]
		next_ip = FETCH_ADDR;
		if (st_pop) begin
			next_ip = st_top;
		end else if (st_push || (IP_JUMP && !PROG_MODE)) begin
			next_ip = IP_TARGET; // see [RQ2]
		end else if (IP_STEP && !PROG_MODE) begin
			next_ip = FETCH_ADDR + 1'b1; // wraps within 4K
		end
	end

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			FETCH_ADDR <= `MSO_RESET_IP;
			STACK_OVF  <= 1'b0;
		end else begin
			FETCH_ADDR <= next_ip; // see [RQ1]
			STACK_OVF  <= ovf;
		end
	end

	mso_retstack u_stack (
		.clk       (MCLK),
		.rst_n     (NRST),
		.push      (st_push),
		.pop       (st_pop),
		.push_data (FETCH_ADDR),
		.top       (st_top),
		.depth     (st_depth),
		.ovf       (ovf)
	);

	// data space storage
	logic [7:0]                 ram [0:`MSO_RAM_WORDS-1];
	logic [7:0]                 idx [0:3];
	logic [7:0]                 acc, next_acc, next_ior;
	logic [`MSO_WSEL_W-1:0]     wsel, next_wsel;
	logic [`MSO_PORT_BITS-1:0]  popt, next_pdat, next_pdir, next_popt;
	logic [4:0]                 pbase;
	mso_region_t                wr_rg;

	always_comb begin
		wr_rg     = region_of(DATA_ADDR);
		pbase     = {DATA_ADDR[1:0], 3'h0};
		next_acc  = acc;
		next_ior  = INT_OPTION;
		next_wsel = wsel;
		next_pdat = PORT_OUT;
		next_pdir = PORT_OE;
		next_popt = popt; // kept apart from the pull-up so an output pin keeps its option
		if (DATA_WR && !PROG_MODE) begin
			case (wr_rg)
				MSO_RG_ACC:  next_acc = DATA_WDATA;
				MSO_RG_IOR:  next_ior = DATA_WDATA;
				MSO_RG_WSEL: next_wsel = DATA_WDATA[`MSO_WSEL_W-1:0]; // see [RQ13]
				MSO_RG_PDAT: next_pdat[pbase +: 8] = DATA_WDATA;
				MSO_RG_PDIR: next_pdir[pbase +: 8] = DATA_WDATA; // see [RQ10]
				MSO_RG_POPT: next_popt[pbase +: 8] = DATA_WDATA; // see [RQ10]
				default:     next_acc = acc; // ram and index files below; window is read-only
			endcase
		end
	end

	// index and short direct words come up undefined in use and are cleared on reset; ram words have no reset
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			acc         <= `MSO_BYTE_RST;
			INT_OPTION  <= `MSO_BYTE_RST;
			wsel        <= `MSO_WSEL_RST;
			PORT_OUT    <= `MSO_PORT_RST;
			PORT_OE     <= `MSO_PORT_RST; // see [RQ10]
			PORT_PULLUP <= `MSO_PULL_RST; // see [RQ10]
			popt        <= `MSO_PORT_RST;
		end else begin
			acc         <= next_acc;
			INT_OPTION  <= next_ior;
			wsel        <= next_wsel;
			PORT_OUT    <= next_pdat;
			PORT_OE     <= next_pdir;
			PORT_PULLUP <= ~next_pdir & ~next_popt;
			popt        <= next_popt;
		end
	end

	for (genvar i = 0; i < `MSO_RAM_WORDS; i++) begin : g_ram
		always_ff @(posedge MCLK) begin
			if (DATA_WR && !PROG_MODE && wr_rg == MSO_RG_RAM && DATA_ADDR[5:0] == 6'(i)) begin
				ram[i] <= DATA_WDATA; // see [RQ5]
			end
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_idx
		always_ff @(posedge MCLK) begin
			if (!NRST) begin
				idx[i] <= `MSO_BYTE_RST;
			end else if (DATA_WR && !PROG_MODE && wr_rg == MSO_RG_IDX && DATA_ADDR[1:0] == 2'(i)) begin
				idx[i] <= DATA_WDATA; // see [RQ5]
			end
		end
	end

	// read path: direct reads answer next cycle, window and readout one later
	mso_rd_state_t            rd_st, next_rd_st;
	logic [7:0]               next_rdata, next_ext_data, rd_byte;
	logic                     next_rvalid, next_ext_valid, next_ext_ref, next_rom_rd;
	logic [`MSO_IP_W-1:0]     next_rom_addr;
	logic [`MSO_PORT_BITS-1:0] port_view;

	always_comb begin
		port_view      = (PORT_OUT & PORT_OE) | (pin_s2 & ~PORT_OE);
		next_rd_st     = MSO_RD_IDLE;
		next_rdata     = DATA_RDATA;
		next_rvalid    = 1'b0;
		next_ext_data  = EXT_RD_DATA;
		next_ext_valid = 1'b0;
		next_ext_ref   = 1'b0;
		next_rom_rd    = 1'b0;
		next_rom_addr  = ROM_RADDR;
		case (region_of(DATA_ADDR))
			MSO_RG_RAM:  rd_byte = ram[DATA_ADDR[5:0]];
			MSO_RG_IDX:  rd_byte = idx[DATA_ADDR[1:0]];
			MSO_RG_ACC:  rd_byte = acc;
			MSO_RG_PDAT: rd_byte = port_view[pbase +: 8];
			MSO_RG_PDIR: rd_byte = PORT_OE[pbase +: 8];
			MSO_RG_POPT: rd_byte = popt[pbase +: 8];
			default:     rd_byte = `MSO_BYTE_RST; // write-only and unmapped read zero
		endcase
		case (rd_st)
			MSO_RD_IDLE: begin
				if (EXT_RD_REQ) begin
					if (PROTECTED || !PROG_MODE) begin
						next_ext_ref = 1'b1; // see [RQ6]
					end else begin
						next_rom_rd   = 1'b1;
						next_rom_addr = EXT_RD_ADDR;
						next_rd_st    = MSO_RD_EXT;
					end
				end else if (DATA_RD && !PROG_MODE) begin
					if (region_of(DATA_ADDR) == MSO_RG_WIN) begin
						next_rom_rd   = 1'b1; // see [RQ4]
						next_rom_addr = {wsel, DATA_ADDR[`MSO_WOFS_W-1:0]}; // see [RQ14]
						next_rd_st    = MSO_RD_WIN;
					end else begin
						next_rdata  = rd_byte;
						next_rvalid = 1'b1;
					end
				end
			end
			MSO_RD_WIN: begin
				next_rdata  = ROM_RDATA; // see [RQ4]
				next_rvalid = 1'b1;
			end
			MSO_RD_EXT: begin
				next_ext_data  = ROM_RDATA;
				next_ext_valid = 1'b1;
			end
			default: next_rd_st = MSO_RD_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			rd_st          <= MSO_RD_IDLE;
			DATA_RDATA     <= `MSO_BYTE_RST;
			DATA_RVALID    <= 1'b0;
			EXT_RD_DATA    <= `MSO_BYTE_RST;
			EXT_RD_VALID   <= 1'b0;
			EXT_RD_REFUSED <= 1'b0;
			ROM_RD         <= 1'b0;
			ROM_RADDR      <= '0;
		end else begin
			rd_st          <= next_rd_st;
			DATA_RDATA     <= next_rdata;
			DATA_RVALID    <= next_rvalid;
			EXT_RD_DATA    <= next_ext_data;
			EXT_RD_VALID   <= next_ext_valid;
			EXT_RD_REFUSED <= next_ext_ref;
			ROM_RD         <= next_rom_rd;
			ROM_RADDR      <= next_rom_addr;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	sequence s_win_issue;
		rd_st == MSO_RD_IDLE && !EXT_RD_REQ && DATA_RD && !PROG_MODE
			&& region_of(DATA_ADDR) == MSO_RG_WIN;
	endsequence

	sequence s_call;
		IP_CALL && !IP_RET && !PROG_MODE;
	endsequence

	AST_WIN_ADDR: assert property (s_win_issue |=> ROM_RD // see [RQ14]
		&& ROM_RADDR == {$past(wsel), $past(DATA_ADDR[5:0])})
		else $error("window read used a wrong program address");

	AST_WIN_DATA: assert property (s_win_issue |-> ##1 !DATA_RVALID ##1 // see [RQ4]
		DATA_RVALID && DATA_RDATA == $past(ROM_RDATA))
		else $error("window data not returned two cycles after request");

	AST_NMI_FALL: assert property ($fell(nmi_s2) && !PROG_MODE |=> NMI_REQ) // see [RQ8]
		else $error("falling edge on interrupt pin missed");

	AST_NMI_LEVEL: assert property (!nmi_s2 && !$past(nmi_s2) |=> !NMI_REQ) // see [RQ8]
		else $error("low level retriggered the interrupt");

	AST_PROT_REFUSE: assert property (rd_st == MSO_RD_IDLE && EXT_RD_REQ && PROTECTED // see [RQ6]
		|=> EXT_RD_REFUSED && !ROM_RD ##1 !EXT_RD_VALID)
		else $error("protected readout was not refused");

	AST_ERASE_ONLY: assert property ($fell(PROTECTED) |-> ERASE_ALL // see [RQ7]
		&& $past(ERASE_REQ) && $past(PROG_MODE))
		else $error("protection cleared without full erase");

	AST_PORT_HOLD: assert property (!$past(DATA_WR) |-> $stable(PORT_OE) // see [RQ10]
		&& $stable(PORT_PULLUP))
		else $error("port configuration changed without a write");

	AST_PORT_RESET: assert property ($rose(NRST) |-> PORT_OE == `MSO_PORT_RST // see [RQ10]
		&& PORT_PULLUP == `MSO_PULL_RST)
		else $error("ports not input with pull-up after reset");

	AST_CALL_RET: assert property (s_call ##1 (IP_RET && !PROG_MODE) // see [RQ3]
		|=> FETCH_ADDR == $past(FETCH_ADDR, 2))
		else $error("return did not restore saved pointer");

	AST_CALL_TGT: assert property (s_call |=> FETCH_ADDR == $past(IP_TARGET)) // see [RQ2]
		else $error("call target not loaded");

	AST_RST_PRIO: assert property (@(posedge MCLK) disable iff (1'b0) // see [RQ9]
		!NRST |=> !NMI_REQ && FETCH_ADDR == `MSO_RESET_IP)
		else $error("reset did not override interrupt and pointer");

	// the level synchroniser is only known after two reset edges
	AST_VPP_MODE: assert property (@(posedge MCLK) disable iff (1'b0) // see [RQ11]
		!NRST [*3] |=> PROG_MODE == $past(vpp_s2))
		else $error("programming level not caught during reset");

endmodule : mso_memspace

// >>> tb/mso_tb.sv
`timescale 1ns/1ps
`include "mso_params.svh"

// one compare: counts it, reports a mismatch at once
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module tb import mso_pkg::*; ;
	// clock, reset and pins
	logic        MCLK = 1'b0, NRST = 1'b0, NMI_PIN = 1'b1, VPP_HIGH = 1'b0;
	logic [23:0] PORT_PIN_IN = 24'h000000;
	logic [23:0] PORT_OUT, PORT_OE, PORT_PULLUP;
	// option cell and programmer
	logic        OPT_PROTECT = 1'b0, PROT_SET = 1'b0, ERASE_REQ = 1'b0, EXT_RD_REQ = 1'b0;
	logic [11:0] EXT_RD_ADDR = 12'h000;
	logic [7:0]  EXT_RD_DATA;
	logic        EXT_RD_VALID, EXT_RD_REFUSED, ERASE_ALL, PROG_MODE, PROTECTED;
	// pointer and data space
	logic        IP_STEP = 1'b0, IP_JUMP = 1'b0, IP_CALL = 1'b0, IP_INT = 1'b0, IP_RET = 1'b0;
	logic [11:0] IP_TARGET = 12'h000;
	logic [11:0] FETCH_ADDR, ROM_RADDR;
	logic        STACK_OVF, NMI_REQ, DATA_RVALID, ROM_RD;
	logic        DATA_RD = 1'b0, DATA_WR = 1'b0;
	logic [7:0]  DATA_ADDR = 8'h00, DATA_WDATA = 8'h00;
	logic [7:0]  DATA_RDATA, INT_OPTION, ROM_RDATA;
	// bench state
	int          bad_count = 0, cmp_count = 0, nmi_cnt = 0, n0, i;
	logic [7:0]  qd[$], qe[$], e8, v8, adr[5];
	logic [11:0] qa[$], e12, tg[7];
	logic [5:0]  cur_sel, ofs;

	mso_memspace dut (.MCLK(MCLK), .NRST(NRST), .NMI_PIN(NMI_PIN), .VPP_HIGH(VPP_HIGH),
		.PORT_PIN_IN(PORT_PIN_IN), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE),
		.PORT_PULLUP(PORT_PULLUP), .OPT_PROTECT(OPT_PROTECT), .PROT_SET(PROT_SET),
		.ERASE_REQ(ERASE_REQ), .EXT_RD_REQ(EXT_RD_REQ), .EXT_RD_ADDR(EXT_RD_ADDR),
		.EXT_RD_DATA(EXT_RD_DATA), .EXT_RD_VALID(EXT_RD_VALID),
		.EXT_RD_REFUSED(EXT_RD_REFUSED), .ERASE_ALL(ERASE_ALL), .PROG_MODE(PROG_MODE),
		.PROTECTED(PROTECTED), .IP_STEP(IP_STEP), .IP_JUMP(IP_JUMP), .IP_CALL(IP_CALL),
		.IP_INT(IP_INT), .IP_RET(IP_RET), .IP_TARGET(IP_TARGET), .FETCH_ADDR(FETCH_ADDR),
		.STACK_OVF(STACK_OVF), .NMI_REQ(NMI_REQ), .DATA_RD(DATA_RD), .DATA_WR(DATA_WR),
		.DATA_ADDR(DATA_ADDR), .DATA_WDATA(DATA_WDATA), .DATA_RDATA(DATA_RDATA),
		.DATA_RVALID(DATA_RVALID), .INT_OPTION(INT_OPTION), .ROM_RADDR(ROM_RADDR),
		.ROM_RD(ROM_RD), .ROM_RDATA(ROM_RDATA));

	// program memory contents, a scramble of the address
	function automatic logic [7:0] romf(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
	endfunction : romf

	// memory answers only while read strobe is high; otherwise the inverse
	assign ROM_RDATA = ROM_RD ? romf(ROM_RADDR) : ~romf(ROM_RADDR);

	// 10 MHz clock
	always #50 MCLK = ~MCLK;

	// monitor: results checked mid-cycle against the oldest note
	always @(negedge MCLK) begin
		if (NMI_REQ === 1'b1) nmi_cnt++;
		if (DATA_RVALID === 1'b1) begin
			e8 = (qd.size() > 0) ? qd.pop_front() : ~DATA_RDATA;
			`CHK("data rdata", e8, DATA_RDATA)
		end
		if (EXT_RD_VALID === 1'b1) begin
			e8 = (qe.size() > 0) ? qe.pop_front() : ~EXT_RD_DATA;
			`CHK("ext rdata", e8, EXT_RD_DATA)
		end
		if (ROM_RD === 1'b1) begin
			e12 = (qa.size() > 0) ? qa.pop_front() : ~ROM_RADDR;
			`CHK("rom raddr", e12, ROM_RADDR)
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
	endtask : tick

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	// reset with chosen programming level, option bit and nmi level
	task automatic do_reset(input logic v, p, n);
		@(posedge MCLK);
		NRST <= 1'b0;
		VPP_HIGH <= v;
		OPT_PROTECT <= p;
		NMI_PIN <= n;
		tick(5);
		NRST <= 1'b1;
		@(negedge MCLK);
	endtask : do_reset

	task automatic wr(input logic [7:0] a, d);
		@(posedge MCLK);
		DATA_WR <= 1'b1;
		DATA_ADDR <= a;
		DATA_WDATA <= d;
		@(posedge MCLK);
		DATA_WR <= 1'b0;
	endtask : wr

	// bare read strobe; idle cycles after it cover the window latency
	task automatic pr(input logic [7:0] a);
		@(posedge MCLK);
		DATA_RD <= 1'b1;
		DATA_ADDR <= a;
		@(posedge MCLK);
		DATA_RD <= 1'b0;
		tick(3);
	endtask : pr

	task automatic rd(input logic [7:0] a, e);
		qd.push_back(e);
		if (a >= 8'h40 && a <= 8'h7f) qa.push_back({cur_sel, a[5:0]});
		pr(a);
	endtask : rd

	task automatic ext(input logic [11:0] a, input logic ok);
		if (ok) begin
			qe.push_back(romf(a));
			qa.push_back(a);
		end
		@(posedge MCLK);
		EXT_RD_REQ <= 1'b1;
		EXT_RD_ADDR <= a;
		@(posedge MCLK);
		EXT_RD_REQ <= 1'b0;
		@(negedge MCLK);
		`CHK("ext refused", !ok, EXT_RD_REFUSED)
		tick(3);
	endtask : ext

	// one pointer request: 0 step, 1 jump, 2 call, 3 int, 4 return
	task automatic ipc(input int k, input logic [11:0] t);
		@(posedge MCLK);
		{IP_STEP, IP_JUMP, IP_CALL, IP_INT, IP_RET} <= 5'h10 >> k;
		IP_TARGET <= t;
		@(posedge MCLK);
		{IP_STEP, IP_JUMP, IP_CALL, IP_INT, IP_RET} <= 5'h00;
		@(negedge MCLK);
	endtask : ipc

	// watchdog: whole run needs a few hundred cycles
	initial begin
		#3000000;
		bad_count++;
		$display("[ERR] watchdog expired");
		results();
	end

	// main sequence
	initial begin
		void'($urandom(32'hd12ad445));
		tick(5);
		NRST <= 1'b1;
		PORT_PIN_IN <= 24'($urandom);
		@(negedge MCLK);
		`CHK("fetch reset", 12'hffe, FETCH_ADDR)
		`CHK("port oe reset", 24'h000000, PORT_OE)
		`CHK("pullup reset", 24'hffffff, PORT_PULLUP)
		`CHK("port out reset", 24'h000000, PORT_OUT)
		$display("test reset done");

		// ram, index, short direct and accumulator hold what was written
		adr = '{8'h00, 8'h3f, 8'h80, 8'h83, 8'hff};
		for (i = 0; i < 5; i++) begin
			v8 = 8'($urandom);
			wr(adr[i], v8);
			rd(adr[i], v8);
		end
		wr(8'hc8, 8'h5c);
		@(negedge MCLK);
		`CHK("int option", 8'h5c, INT_OPTION)
		rd(8'hc8, 8'h00);
		rd(8'h90, 8'h00);
		rd(8'hc0, PORT_PIN_IN[7:0]);
		rd(8'hc1, PORT_PIN_IN[15:8]);
		wr(8'hc4, 8'hff);
		wr(8'hc0, 8'ha6);
		@(negedge MCLK);
		`CHK("port oe", 8'hff, PORT_OE[7:0])
		`CHK("pullup", 8'h00, PORT_PULLUP[7:0])
		`CHK("pullup c", 8'hff, PORT_PULLUP[23:16])
		rd(8'hc0, 8'ha6);
		// back to input: the untouched option bits must bring the pull-up back
		wr(8'hc4, 8'h00);
		@(negedge MCLK);
		`CHK("pullup back", 8'hff, PORT_PULLUP[7:0])
		$display("test data space done");

		// window: block number above low six address bits
		for (i = 0; i < 4; i++) begin
			cur_sel = (i == 0) ? 6'h3f : 6'($urandom);
			ofs = (i == 1) ? 6'h00 : 6'($urandom);
			wr(8'hc9, {2'b00, cur_sel});
			wr(8'h40 + ofs, 8'h00);
			rd(8'h40 + ofs, romf({cur_sel, ofs}));
		end
		rd(8'h7f, romf({cur_sel, 6'h3f}));
		rd(8'hc9, 8'h00);
		$display("test window done");

		// pointer: step, seven nested calls (the fourth an interrupt entry), jump, six returns
		ipc(0, 12'h000);
		`CHK("step", 12'hfff, FETCH_ADDR)
		for (i = 0; i < 7; i++) begin
			tg[i] = 12'($urandom);
			ipc((i == 3) ? 3 : 2, tg[i]);
			`CHK("call target", tg[i], FETCH_ADDR)
			// overflow flag is registered once more at the top, one edge after the push
			@(negedge MCLK);
			`CHK("stack ovf", (i == 6), STACK_OVF)
		end
		ipc(1, 12'h555);
		`CHK("jump", 12'h555, FETCH_ADDR)
		for (i = 5; i >= 0; i--) begin
			ipc(4, 12'h000);
			`CHK("return", tg[i], FETCH_ADDR)
		end
		$display("test pointer done");

		// nmi: falling edge gives one pulse three edges on, the low level none
		@(posedge MCLK);
		NMI_PIN <= 1'b0;
		tick(2);
		@(negedge MCLK);
		`CHK("nmi early", 1'b0, NMI_REQ)
		@(negedge MCLK);
		`CHK("nmi edge", 1'b1, NMI_REQ)
		// let the monitor count the pulse before taking the reference
		tick(1);
		n0 = nmi_cnt;
		tick(10);
		`CHK("nmi level", n0, nmi_cnt)
		@(posedge MCLK);
		NMI_PIN <= 1'b1;
		tick(4);
		ext(12'($urandom), 1'b0);
		$display("test nmi done");

		// programming mode: readout, protect, erase, frozen core
		do_reset(1'b1, 1'b0, 1'b1);
		tick(1);
		@(negedge MCLK);
		`CHK("prog mode", 1'b1, PROG_MODE)
		`CHK("protected", 1'b0, PROTECTED)
		ext(12'($urandom), 1'b1);
		ext(12'hfff, 1'b1);
		pr(8'h00);
		ipc(2, 12'h123);
		`CHK("frozen ip", 12'hffe, FETCH_ADDR)
		@(posedge MCLK);
		PROT_SET <= 1'b1;
		@(posedge MCLK);
		PROT_SET <= 1'b0;
		@(negedge MCLK);
		`CHK("prot set", 1'b1, PROTECTED)
		ext(12'($urandom), 1'b0);
		@(posedge MCLK);
		ERASE_REQ <= 1'b1;
		@(posedge MCLK);
		ERASE_REQ <= 1'b0;
		@(negedge MCLK);
		`CHK("erase all", 1'b1, ERASE_ALL)
		`CHK("prot clear", 1'b0, PROTECTED)
		ext(12'($urandom), 1'b1);
		$display("test programming done");

		// protected part, nmi edge lost under reset
		n0 = nmi_cnt;
		do_reset(1'b0, 1'b1, 1'b0);
		repeat (6) @(negedge MCLK);
		`CHK("nmi in reset", n0, nmi_cnt)
		`CHK("prog off", 1'b0, PROG_MODE)
		`CHK("opt protect", 1'b1, PROTECTED)
		`CHK("fetch again", 12'hffe, FETCH_ADDR)
		ext(12'($urandom), 1'b0);
		$display("test protect done");
		results();
	end
endmodule : tb
